/* hw/tdc_pkg.sv */
package tdc_pkg;

  // Word indices on the register bus; byte address is four times the index
  localparam logic [5:0] IdxMode       = 6'h00;
  localparam logic [5:0] IdxDecay      = 6'h01;
  localparam logic [5:0] IdxArrival    = 6'h02;
  localparam logic [5:0] IdxDeparture  = 6'h03;
  localparam logic [5:0] IdxLength     = 6'h04;
  localparam logic [5:0] IdxWidth      = 6'h05;
  localparam logic [5:0] IdxChange     = 6'h06;
  localparam logic [5:0] IdxCentreHigh = 6'h07;
  localparam logic [5:0] IdxBandLow0   = 6'h08;
  localparam logic [5:0] IdxSelect     = 6'h0e;
  localparam logic [5:0] IdxStatus     = 6'h0f;

  // Mode register fields
  localparam int unsigned ModeScaleLo  = 0;
  localparam int unsigned ModeAckLo    = 2;
  localparam int unsigned ModeToneEn   = 5;
  localparam logic [2:0]  AckToneChange = 3'h4;

  // Values after reset
  localparam logic [7:0] RstDecay     = 8'h78;
  localparam logic [7:0] RstArrival   = 8'hff;
  localparam logic [7:0] RstDeparture = 8'hff;
  localparam logic [7:0] RstLength    = 8'h32;
  localparam logic [5:0] RstSelect    = 6'h3f;

  // Envelope arithmetic: decay is a fraction of 1024
  localparam int unsigned DecayShift = 10;
  localparam int unsigned NumBands   = 6;

  // Samples per filtering operation: 16384 / (code + 16) + 1
  function automatic logic [10:0] calcLength(input logic [7:0] code);
    logic [14:0] quo;
    quo = 15'h4000 / (15'(code) + 15'h0010);
    calcLength = 11'(quo) + 11'h001;
  endfunction : calcLength

  // Left shift that realises the selected input gain
  function automatic logic [2:0] gainShift(input logic [1:0] sel);
    logic [2:0] sh;
    sh = 3'h2;
    if (sel == 2'h2)
    begin
      sh = 3'h0;
    end
    else if (sel == 2'h3)
    begin
      sh = 3'h4;
    end
    gainShift = sh;
  endfunction : gainShift

endpackage : tdc_pkg

/* hw/tdc_env_if.sv */
`timescale 1ns/1ps
interface tdc_env_if;
  logic       sampleValid;
  logic [7:0] level;
  logic [7:0] decay;
  logic [7:0] env;

  modport ctrl     (output sampleValid, output level, output decay, input env);
  modport detector (input sampleValid, input level, input decay, output env);
endinterface : tdc_env_if

/* hw/tdc_envelope.sv */
`timescale 1ns/1ps
module tdc_envelope (
  // Clock and reset
  input wire logic     mclk,
  input wire logic     rstn,
  input wire logic     clkEn,
  // Link to the controller
  tdc_env_if.detector  envIf
);

  typedef struct packed {
    logic [17:0] acc;
  } tdc_env_state_t;

  tdc_env_state_t     s_q;
  tdc_env_state_t     s_d;
  logic signed [18:0] diff;
  logic signed [27:0] step;

  // First-order smoothing, acc holds level times 1024
  always_comb
  begin
    s_d  = s_q;
    diff = signed'({1'b0, envIf.level, 10'h000}) - signed'({1'b0, s_q.acc});
    step = (28'(diff) * signed'(28'(envIf.decay))) >>> tdc_pkg::DecayShift;
    if (envIf.sampleValid)
    begin
      s_d.acc = 18'(28'(s_q.acc) + step);
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q <= '0;
    end
    else if (clkEn)
    begin
      s_q <= s_d;
    end
  end

  assign envIf.env = s_q.acc[17:10];

  AST_ZERO_DECAY_HOLDS: assert property (@(posedge mclk) disable iff (!rstn)
    clkEn && envIf.decay == 8'h00 |=> $stable(s_q.acc))
    else $error("Envelope moved with zero decay");

endmodule : tdc_envelope

/* hw/tdc_tone_config.sv */
// The AHB-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ps
// Contract
// - Input scaled by one of three gains from the mode scale field before detection.
// - Decay value sets envelope time constant as a fraction of 1024.
// - Decay value resets to 120.
// - Arrival when envelope reaches the arrival level.
// - Departure when envelope falls to the departure level.
// - Departure level above arrival level serves as both thresholds.
// - Arrival and departure levels reset to 255.
// - Operation takes 16384/(length code + 16) + 1 samples.
// - New length code is used only from the next operation start.
// - Length code resets to 50, giving 250 samples; the integer division in the code gives 249.
// - Width code is six bits, bandwidth times 0.128.
// - Passband is symmetric about each band centre.
// - After each operation except first after onset, level crossings flag tone change.
// - New change threshold applies from the next comparison.
// - High byte is held; writing a band low byte joins both.
// - Centre specifier is high byte times 256 plus low byte.
// - Select bits D5..D0 for bands one..six choose wide or zero width.
// - Select bits reset to all ones.
// - Writes act at once; other write registers reset to zero.
// - Tone change flag is active low, returned high by host acknowledge.
module tdc_tone_config (
  // Clock, reset, enable
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        clkEn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // Codec samples
  input  wire logic        sampleValid,
  input  wire logic [15:0] sample,
  // Band levels from the filter engine at the end of an operation
  input  wire logic        levelValid,
  input  wire logic [47:0] bandLevels,
  // Scaled samples and filter setup
  output logic             scaledValid,
  output logic [19:0]      scaledSample,
  output logic [95:0]      bandCentres,
  output logic [35:0]      bandWidths,
  output logic [10:0]      opSamples,
  output logic             opStart,
  output logic             opDone,
  // Detection state
  output logic             toneOn,
  output logic             toneArrival,
  output logic             toneDeparture,
  output logic             toneChangeFlagN
);

  typedef struct packed {
    logic [7:0]       mode;
    logic [7:0]       decay;
    logic [7:0]       arrival;
    logic [7:0]       departure;
    logic [7:0]       length;
    logic [5:0]       width;
    logic [7:0]       change;
    logic [7:0]       centreHigh;
    logic [5:0][15:0] centre;
    logic [5:0]       select;
    logic             wrPend;
    logic [5:0]       wrIdx;
    logic [31:0]      rdata;
    logic             ready;
    logic             gainedValid;
    logic [19:0]      gained;
    logic [5:0][5:0]  widths;
    logic             toneOn;
    logic             arrivalPulse;
    logic             departurePulse;
    logic             firstOp;
    logic             opActive;
    logic [10:0]      opSamples;
    logic [10:0]      sampleCnt;
    logic             opStart;
    logic             opDone;
    logic             changeN;
    logic [5:0][7:0]  prevLevels;
  } tdc_state_t;

  tdc_state_t   s_q;
  tdc_state_t   s_d;
  tdc_env_if    envIf ();
  logic [19:0]  mag;
  logic [7:0]   effArrival;
  logic [7:0]   effDeparture;
  logic         addrTaken;
  logic         crossed;
  logic         ackChange;

  tdc_envelope u_envelope (
    .mclk  (mclk),
    .rstn  (rstn),
    .clkEn (clkEn),
    .envIf (envIf)
  );

  // Envelope sees the scaled sample straight from the gain register, in the cycle after it arrives
  assign mag               = s_q.gained[19] ? 20'(-s_q.gained) : s_q.gained;
  assign envIf.sampleValid = s_q.gainedValid;
  assign envIf.level       = mag[19] ? 8'hff : mag[18:11];
  assign envIf.decay       = s_q.decay;

  assign effArrival   = (s_q.departure > s_q.arrival) ? s_q.departure : s_q.arrival;
  assign effDeparture = s_q.departure;
  assign addrTaken    = hsel && htrans[1] && hready;
  assign ackChange    = s_q.wrPend && s_q.wrIdx == tdc_pkg::IdxMode
                        && hwdata[tdc_pkg::ModeAckLo +: 3] == tdc_pkg::AckToneChange;

  always_comb
  begin
    s_d            = s_q;
    crossed        = 1'b0;
    s_d.ready      = 1'b1;
    s_d.opStart    = 1'b0;
    s_d.opDone     = 1'b0;
    s_d.arrivalPulse   = 1'b0;
    s_d.departurePulse = 1'b0;

    // Register writes land in the data phase and act at once
    s_d.wrPend = addrTaken && hwrite;
    s_d.wrIdx  = haddr[7:2];
    if (s_q.wrPend)
    begin
      unique case (s_q.wrIdx)
        tdc_pkg::IdxMode:       s_d.mode       = hwdata[7:0];
        tdc_pkg::IdxDecay:      s_d.decay      = hwdata[7:0];
        tdc_pkg::IdxArrival:    s_d.arrival    = hwdata[7:0];
        tdc_pkg::IdxDeparture:  s_d.departure  = hwdata[7:0];
        tdc_pkg::IdxLength:     s_d.length     = hwdata[7:0];
        tdc_pkg::IdxWidth:      s_d.width      = hwdata[5:0];
        tdc_pkg::IdxChange:     s_d.change     = hwdata[7:0];
        tdc_pkg::IdxCentreHigh: s_d.centreHigh = hwdata[7:0];
        tdc_pkg::IdxSelect:     s_d.select     = hwdata[5:0];
        default:
        begin
          for (int b = 0; b < tdc_pkg::NumBands; b++)
          begin
            if (s_q.wrIdx == tdc_pkg::IdxBandLow0 + 6'(b))
            begin
              s_d.centre[b] = {s_q.centreHigh, hwdata[7:0]};
            end
          end
        end
      endcase
    end

    // Read data is prepared in the address phase from current state
    if (addrTaken && !hwrite)
    begin
      unique case (haddr[7:2])
        tdc_pkg::IdxMode:       s_d.rdata = {24'h000000, s_q.mode};
        tdc_pkg::IdxDecay:      s_d.rdata = {24'h000000, s_q.decay};
        tdc_pkg::IdxArrival:    s_d.rdata = {24'h000000, s_q.arrival};
        tdc_pkg::IdxDeparture:  s_d.rdata = {24'h000000, s_q.departure};
        tdc_pkg::IdxLength:     s_d.rdata = {24'h000000, s_q.length};
        tdc_pkg::IdxWidth:      s_d.rdata = {26'h0000000, s_q.width};
        tdc_pkg::IdxChange:     s_d.rdata = {24'h000000, s_q.change};
        tdc_pkg::IdxCentreHigh: s_d.rdata = {24'h000000, s_q.centreHigh};
        tdc_pkg::IdxSelect:     s_d.rdata = {26'h0000000, s_q.select};
        tdc_pkg::IdxStatus:     s_d.rdata = {16'h0000, envIf.env, 6'h00, s_q.toneOn,
                                             s_q.changeN};
        default:
        begin
          s_d.rdata = 32'h00000000;
          for (int b = 0; b < tdc_pkg::NumBands; b++)
          begin
            if (haddr[7:2] == tdc_pkg::IdxBandLow0 + 6'(b))
            begin
              s_d.rdata = {16'h0000, s_q.centre[b]};
            end
          end
        end
      endcase
    end

    // Gain stage ahead of envelope and filters
    s_d.gainedValid = sampleValid;
    if (sampleValid)
    begin
      s_d.gained = 20'(signed'(sample)) <<<
                   tdc_pkg::gainShift(s_q.mode[tdc_pkg::ModeScaleLo +: 2]);
    end

    // Band D5 is band one; a cleared bit narrows the band to zero width
    for (int b = 0; b < tdc_pkg::NumBands; b++)
    begin
      s_d.widths[b] = s_q.select[5 - b] ? s_q.width : 6'h00;
    end

    // Tone presence from the envelope
    if (!s_q.mode[tdc_pkg::ModeToneEn])
    begin
      s_d.toneOn   = 1'b0;
      s_d.opActive = 1'b0;
    end
    else if (!s_q.toneOn && envIf.env >= effArrival)
    begin
      s_d.toneOn       = 1'b1;
      s_d.arrivalPulse = 1'b1;
      s_d.firstOp      = 1'b1;
    end
    else if (s_q.toneOn && envIf.env <= effDeparture)
    begin
      s_d.toneOn         = 1'b0;
      s_d.departurePulse = 1'b1;
      s_d.opActive       = 1'b0;
    end
    else if (s_q.toneOn && !s_q.opActive)
    begin
      // Length is sampled only here, so a rewrite waits for the next operation
      s_d.opActive  = 1'b1;
      s_d.opStart   = 1'b1;
      s_d.sampleCnt = 11'h000;
      s_d.opSamples = tdc_pkg::calcLength(s_q.length);
    end
    else if (s_q.opActive && s_q.gainedValid)
    begin
      s_d.sampleCnt = s_q.sampleCnt + 11'h001;
      if (s_q.sampleCnt == s_q.opSamples - 11'h001)
      begin
        s_d.opActive = 1'b0;
        s_d.opDone   = 1'b1;
      end
    end

    // Compare band levels against the previous operation
    if (levelValid)
    begin
      for (int b = 0; b < tdc_pkg::NumBands; b++)
      begin
        if ((bandLevels[8*b +: 8] >= s_q.change) != (s_q.prevLevels[b] >= s_q.change))
        begin
          crossed = 1'b1;
        end
      end
      s_d.prevLevels = bandLevels;
      s_d.firstOp    = 1'b0;
    end

    // Acknowledge raises the flag; a change in the same cycle wins
    if (ackChange)
    begin
      s_d.changeN = 1'b1;
    end
    if (levelValid && crossed && !s_q.firstOp)
    begin
      s_d.changeN = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q           <= '0;
      s_q.decay     <= tdc_pkg::RstDecay;
      s_q.arrival   <= tdc_pkg::RstArrival;
      s_q.departure <= tdc_pkg::RstDeparture;
      s_q.length    <= tdc_pkg::RstLength;
      s_q.select    <= tdc_pkg::RstSelect;
      s_q.ready     <= 1'b1;
      s_q.changeN   <= 1'b1;
    end
    else if (clkEn)
    begin
      s_q <= s_d;
    end
  end

  assign hreadyout       = s_q.ready;
  assign hrdata          = s_q.rdata;
  assign hresp           = 1'b0;
  assign scaledValid     = s_q.gainedValid;
  assign scaledSample    = s_q.gained;
  assign bandCentres     = s_q.centre;
  assign bandWidths      = s_q.widths;
  assign opSamples       = s_q.opSamples;
  assign opStart         = s_q.opStart;
  assign opDone          = s_q.opDone;
  assign toneOn          = s_q.toneOn;
  assign toneArrival     = s_q.arrivalPulse;
  assign toneDeparture   = s_q.departurePulse;
  assign toneChangeFlagN = s_q.changeN;

  AST_UNITY_GAIN: assert property (@(posedge mclk) disable iff (!rstn)
    clkEn && sampleValid && s_q.mode[1:0] == 2'h2 |=> scaledSample == 20'(signed'($past(sample))))
    else $error("Unity gain did not pass sample unchanged");
  AST_DECAY_RESET: assert property (@(posedge mclk) $rose(rstn) |-> s_q.decay == 8'h78)
    else $error("Decay value wrong after reset");
  AST_THRESH_RESET: assert property (@(posedge mclk)
    $rose(rstn) |-> s_q.arrival == 8'hff && s_q.departure == 8'hff)
    else $error("Thresholds wrong after reset");
  // Integer division makes the reset code give 249 samples, one short of the nominal 250
  AST_LENGTH_RESET: assert property (@(posedge mclk)
    $rose(rstn) |-> s_q.length == 8'h32 && opSamples == 11'h000)
    else $error("Length code wrong after reset");
  AST_SELECT_RESET: assert property (@(posedge mclk) $rose(rstn) |-> s_q.select == 6'h3f)
    else $error("Select bits not all one after reset");
  AST_ARRIVAL_LEVEL: assert property (@(posedge mclk) disable iff (!rstn)
    toneArrival |-> $past(envIf.env) >= $past(s_q.arrival)
                    && $past(envIf.env) >= $past(s_q.departure))
    else $error("Arrival below effective threshold");
  AST_DEPARTURE_LEVEL: assert property (@(posedge mclk) disable iff (!rstn)
    toneDeparture |-> !toneOn && $past(envIf.env) <= $past(s_q.departure))
    else $error("Departure above departure level");
  AST_OP_LENGTH: assert property (@(posedge mclk) disable iff (!rstn)
    opStart |-> opSamples == tdc_pkg::calcLength($past(s_q.length)))
    else $error("Operation length wrong");
  AST_LENGTH_HELD: assert property (@(posedge mclk) disable iff (!rstn)
    s_q.opActive && !opStart |-> opSamples == $past(opSamples))
    else $error("Length changed inside an operation");
  AST_CENTRE_JOIN: assert property (@(posedge mclk) disable iff (!rstn)
    clkEn && s_q.wrPend && s_q.wrIdx == tdc_pkg::IdxBandLow0
    |=> bandCentres[15:0] == {$past(s_q.centreHigh), $past(hwdata[7:0])})
    else $error("Band one centre not joined");
  AST_BAND_ONE_WIDTH: assert property (@(posedge mclk) disable iff (!rstn)
    clkEn |=> bandWidths[5:0] == ($past(s_q.select[5]) ? $past(s_q.width) : 6'h00))
    else $error("Band one width not per select bit");
  AST_ACK_RAISES: assert property (@(posedge mclk) disable iff (!rstn)
    clkEn && ackChange && !levelValid |=> toneChangeFlagN)
    else $error("Acknowledge did not raise change flag");
  AST_FIRST_SKIPPED: assert property (@(posedge mclk) disable iff (!rstn)
    clkEn && levelValid && s_q.firstOp && toneChangeFlagN |=> toneChangeFlagN)
    else $error("Change flagged on first operation");

  COV_ARRIVAL:  cover property (@(posedge mclk) disable iff (!rstn) toneArrival);
  COV_OP_DONE:  cover property (@(posedge mclk) disable iff (!rstn) opDone);
  COV_CHANGE:   cover property (@(posedge mclk) disable iff (!rstn) $fell(toneChangeFlagN));
  COV_DEPART:   cover property (@(posedge mclk) disable iff (!rstn) toneDeparture);

endmodule : tdc_tone_config

/* dv/tdc_feed_model.sv */
`timescale 1ns/1ps
module tdc_feed_model (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // Control from the bench
  input  wire logic        run,
  input  wire logic [15:0] amp,
  // Codec and filter engine side
  output logic             sampleValid,
  output logic [15:0]      sample,
  output logic             levelValid,
  output logic [47:0]      bandLevels
);
  logic [1:0] phase;
  logic       neg;

  // One sample every fourth cycle, sign alternating; between samples the
  // line is inverted each cycle so a stale value is never mistaken for data
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      phase       <= 2'h0;
      neg         <= 1'b0;
      sampleValid <= 1'b0;
      sample      <= 16'h0000;
    end
    else
    begin
      phase       <= phase + 2'h1;
      sampleValid <= run && (phase == 2'h0);
      if (run && (phase == 2'h0))
      begin
        sample <= neg ? -amp : amp;
        neg    <= ~neg;
      end
      else
      begin
        sample <= ~sample;
      end
    end
  end

  initial
  begin
    levelValid = 1'b0;
    bandLevels = 48'h0;
  end

  task automatic sendLevels(input logic [47:0] v);
    @(posedge mclk);
    levelValid <= 1'b1;
    bandLevels <= v;
    @(posedge mclk);
    levelValid <= 1'b0;
    bandLevels <= ~v;
  endtask : sendLevels
endmodule : tdc_feed_model

/* dv/tdc_tone_config_tb.sv */
`timescale 1ns/1ps
module tdc_tone_config_tb;
  logic        mclk;
  logic        rstn;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        sampleValid;
  logic [15:0] sample;
  logic        levelValid;
  logic [47:0] bandLevels;
  logic        scaledValid;
  logic [19:0] scaledSample;
  logic [95:0] bandCentres;
  logic [35:0] bandWidths;
  logic [10:0] opSamples;
  logic        opStart;
  logic        opDone;
  logic        toneOn;
  logic        toneDeparture;
  logic        toneArrival;
  logic        toneChangeFlagN;
  logic        run;
  logic [15:0] amp;
  logic [15:0] lastS;
  logic [31:0] rs;
  logic [31:0] r;
  logic [31:0] rd;
  logic [7:0]  len;
  logic [7:0]  hb;
  logic [5:0]  w;
  logic [5:0]  s;
  logic [7:0]  lv;
  int          fails;
  int          checked;
  logic [5:0]  rIdx [11] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07,
                             6'h0e, 6'h0f, 6'h3f};
  logic [31:0] rVal [11] = '{32'h0, 32'h78, 32'hff, 32'hff, 32'h32, 32'h0, 32'h0, 32'h0,
                             32'h3f, 32'h1, 32'h0};

  tdc_tone_config u_dut (
    .mclk(mclk), .rstn(rstn), .clkEn(1'b1),
    .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .sampleValid(sampleValid), .sample(sample),
    .levelValid(levelValid), .bandLevels(bandLevels), .scaledValid(scaledValid),
    .scaledSample(scaledSample), .bandCentres(bandCentres), .bandWidths(bandWidths),
    .opSamples(opSamples), .opStart(opStart), .opDone(opDone), .toneOn(toneOn),
    .toneArrival(toneArrival), .toneDeparture(toneDeparture),
    .toneChangeFlagN(toneChangeFlagN)
  );

  tdc_feed_model u_feed (
    .mclk(mclk), .rstn(rstn), .run(run), .amp(amp), .sampleValid(sampleValid),
    .sample(sample), .levelValid(levelValid), .bandLevels(bandLevels)
  );

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  always @(posedge mclk)
  begin
    if (sampleValid)
    begin
      lastS <= sample;
    end
  end

  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : rnd

  function automatic logic [10:0] expLen(input logic [7:0] c);
    return 11'(32'd16384 / (32'(c) + 32'd16) + 32'd1);
  endfunction : expLen

  function automatic logic [35:0] expWidths(input logic [5:0] wd, input logic [5:0] sel);
    logic [35:0] e;
    for (int b = 0; b < 6; b++)
    begin
      e[6*b+:6] = sel[5-b] ? wd : 6'h00;
    end
    return e;
  endfunction : expWidths

  function automatic logic [19:0] expScaled(input logic [15:0] v, input logic [1:0] g);
    logic [19:0] x;
    x = {{4{v[15]}}, v};
    return (g == 2'h2) ? x : (g == 2'h3) ? (x << 4) : (x << 2);
  endfunction : expScaled

  task automatic chk(input logic [95:0] got, input logic [95:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t %s: got %0h expected %0h", $time, what, got, exp);
    end
  endtask : chk

  // Single word transfer; waits on hready in both phases, never on a fixed count
  task automatic ahbXfer(input logic [5:0] idx, input logic wr, input logic [31:0] wd,
                         output logic [31:0] rdv);
    @(posedge mclk);
    htrans <= 2'h2;
    haddr  <= {24'h0, idx, 2'h0};
    hwrite <= wr;
    do begin @(posedge mclk); end while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge mclk); end while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask : ahbXfer

  task automatic waitHigh(ref logic sig, input int lim, input string what);
    int n;
    n = 0;
    do begin @(posedge mclk); #1; n++; end while (sig !== 1'b1 && n < lim);
    chk({95'h0, sig}, 96'h1, what);
  endtask : waitHigh

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out

  initial
  begin
    #(8 * 60000);
    fails++;
    close_out();
  end

  initial
  begin
    rs = 32'd23; fails = 0; checked = 0; rstn = 1'b0; run = 1'b0; amp = 16'h0;
    htrans = 2'h0; haddr = 32'h0; hwrite = 1'b0; hwdata = 32'h0;
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    for (int i = 0; i < 11; i++)
    begin
      ahbXfer(rIdx[i], 1'b0, 32'h0, rd);
      chk(96'(rd), 96'(rVal[i]), "value after reset");
    end
    chk(96'(hresp), 96'h0, "response code");
    chk(96'(bandWidths), 96'h0, "widths after reset");
    // Gain codes, every pattern of the two scale bits
    r = rnd();
    run <= 1'b1;
    amp <= {1'b0, r[14:0]};
    for (int i = 0; i < 4; i++)
    begin
      ahbXfer(6'h00, 1'b1, 32'(i), rd);
      repeat (12) @(posedge mclk);
      waitHigh(scaledValid, 10, "scaled sample strobe");
      chk(96'(scaledSample), 96'(expScaled(lastS, 2'(i))), "scaled sample");
    end
    // Width and per-band select; first pass puts only band six wide
    for (int i = 0; i < 4; i++)
    begin
      r = rnd();
      w = (i == 0) ? 6'h3f : r[5:0];
      s = (i == 0) ? 6'h01 : r[13:8];
      ahbXfer(6'h05, 1'b1, 32'(w), rd);
      ahbXfer(6'h0e, 1'b1, 32'(s), rd);
      repeat (2) @(posedge mclk);
      #1 chk(96'(bandWidths), 96'(expWidths(w, s)), "band widths");
    end
    // Zero decay freezes the envelope; the reset decay lets silence drain it
    ahbXfer(6'h01, 1'b1, 32'h0, rd);
    ahbXfer(6'h0f, 1'b0, 32'h0, rd);
    lv = rd[15:8];
    amp <= amp ^ 16'h4000;
    repeat (40) @(posedge mclk);
    ahbXfer(6'h0f, 1'b0, 32'h0, rd);
    chk(96'(rd[15:8]), 96'(lv), "envelope frozen");
    ahbXfer(6'h01, 1'b1, 32'h78, rd);
    amp <= 16'h0000;
    repeat (600) @(posedge mclk);
    ahbXfer(6'h0f, 1'b0, 32'h0, rd);
    chk(96'(rd[15:8]), 96'h0, "envelope drained");
    // High byte written only before every other band: the held value must be reused
    for (int i = 0; i < 6; i++)
    begin
      r = rnd();
      if (i % 2 == 0)
      begin
        hb = r[15:8];
        ahbXfer(6'h07, 1'b1, 32'(hb), rd);
      end
      ahbXfer(6'h08 + 6'(i), 1'b1, 32'(r[7:0]), rd);
      #1 chk(96'(bandCentres[16*i+:16]), 96'({hb, r[7:0]}), "band centre");
      ahbXfer(6'h08 + 6'(i), 1'b0, 32'h0, rd);
      chk(96'(rd), 96'({hb, r[7:0]}), "centre readback");
    end
    // Tone arrival and filter length handover
    r = rnd();
    len = r[7:0];
    ahbXfer(6'h04, 1'b1, 32'(len), rd);
    ahbXfer(6'h02, 1'b1, 32'h10, rd);
    ahbXfer(6'h03, 1'b1, 32'h08, rd);
    ahbXfer(6'h06, 1'b1, 32'h40, rd);
    amp <= 16'h7000;
    ahbXfer(6'h00, 1'b1, 32'h23, rd);
    waitHigh(toneOn, 400, "tone arrival");
    waitHigh(opStart, 20, "operation start");
    chk(96'(opSamples), 96'(expLen(len)), "operation length");
    r = rnd();
    // Top bit flipped so the new code always gives a different count
    r[7] = ~len[7];
    ahbXfer(6'h04, 1'b1, 32'(r[7:0]), rd);
    waitHigh(opDone, 4200, "operation end");
    chk(96'(opSamples), 96'(expLen(len)), "length held in flight");
    waitHigh(opStart, 4, "next operation start");
    chk(96'(opSamples), 96'(expLen(r[7:0])), "new length used");
    // First level set after onset is not compared, even though it differs from zero
    u_feed.sendLevels({6{8'h80}});
    @(posedge mclk);
    #1 chk(96'(toneChangeFlagN), 96'h1, "no change on first set");
    u_feed.sendLevels({6{8'h80}});
    @(posedge mclk);
    #1 chk(96'(toneChangeFlagN), 96'h1, "no change on equal set");
    u_feed.sendLevels({8'h80, 8'h80, 8'h80, 8'h10, 8'h80, 8'h80});
    @(posedge mclk);
    #1 chk(96'(toneChangeFlagN), 96'h0, "change flagged");
    ahbXfer(6'h00, 1'b1, 32'h33, rd);
    @(posedge mclk);
    #1 chk(96'(toneChangeFlagN), 96'h1, "change acknowledged");
    // Silence lets the envelope fall to the departure level
    amp <= 16'h0000;
    waitHigh(toneDeparture, 600, "tone departure");
    chk(96'(toneOn), 96'h0, "tone off");
    // Departure level above arrival level governs both
    ahbXfer(6'h03, 1'b1, 32'h30, rd);
    amp <= 16'h1000;
    repeat (300) @(posedge mclk);
    #1 chk(96'(toneOn), 96'h0, "arrival held off");
    amp <= 16'h7000;
    waitHigh(toneArrival, 400, "arrival above raised level");
    chk(96'(toneOn), 96'h1, "tone on after arrival");
    close_out();
  end
endmodule : tdc_tone_config_tb
